// *** hw/scr_consts.svh ***
// constants for the sensor configuration and result register bank
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH

// ==========================================================
// register addresses (7-bit word address on the host link)
`define SCR_ADDR_OSC_TRIM 7'h05
`define SCR_ADDR_BANDGAP_TRIM 7'h06
`define SCR_ADDR_AVG_SETTINGS 7'h07
`define SCR_ADDR_CONFIG 7'h08
`define SCR_ADDR_OBJ_RESULT 7'h09
`define SCR_ADDR_CONV_RESULT 7'h0A
`define SCR_ADDR_MODE 7'h0B
`define SCR_ADDR_WP_KEY 7'h0C

// ==========================================================
// unlock keys
`define SCR_TEST_KEY 7'h59
`define SCR_WP_KEY 7'h65

// ==========================================================
// config field positions
`define SCR_CFG_FIRST_LSB 0
`define SCR_CFG_SECOND_LSB 2
`define SCR_CFG_CURV_POS 4
`define SCR_CFG_CURV_NEG 5
`define SCR_CFG_NTC 6
`define SCR_CFG_INTERVAL_LSB 7

// ==========================================================
// averaging settings field positions
`define SCR_AVG_REF_OPT 0
`define SCR_AVG_OFS_DIS 1
`define SCR_AVG_RESERVED 2
`define SCR_AVG_IR_OFS 3
`define SCR_AVG_T_OFS 4
`define SCR_AVG_IR_LSB 5
`define SCR_AVG_T_LSB 8

// ==========================================================
// result word layout
`define SCR_RES_DATA_LSB 4
`define SCR_RES_OVF 3
`define SCR_RES_UNF 2
`define SCR_RES_FE 1
`define SCR_DATA_MAX 12'hFFF
`define SCR_DATA_MIN 12'h000

// ==========================================================
// reset values
`define SCR_RST_WORD 16'h0000

// ==========================================================
// timing: 125 MHz reference, one second tick
`define SCR_CLK_HZ 125000000
`define SCR_SEC_CYCLES (`SCR_CLK_HZ)

`endif

// *** hw/scr_interval_rom.sv ***
// calibration interval lookup: code to seconds, registered output
`default_nettype none
module scr_interval_rom (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [3:0] code,
    output logic [7:0] seconds
);
    logic [7:0] seconds_ff;
    logic [7:0] nxt_seconds;

    // ==========================================================
    // table
    always_comb begin
        case (code)
            4'h0: nxt_seconds = 8'h00;
            4'h1: nxt_seconds = 8'h02;
            4'h2: nxt_seconds = 8'h11;
            4'h3: nxt_seconds = 8'h13;
            4'h4: nxt_seconds = 8'h43;
            4'h5: nxt_seconds = 8'h45;
            4'h6: nxt_seconds = 8'h54;
            4'h7: nxt_seconds = 8'h56;
            4'h8: nxt_seconds = 8'h86;
            4'h9: nxt_seconds = 8'h88;
            4'hA: nxt_seconds = 8'h97;
            4'hB: nxt_seconds = 8'h99;
            4'hC: nxt_seconds = 8'hC9;
            4'hD: nxt_seconds = 8'hCB;
            4'hE: nxt_seconds = 8'hDA;
            default: nxt_seconds = 8'hDC;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            seconds_ff <= 8'h00;
        end else begin
            seconds_ff <= nxt_seconds;
        end
    end

    assign seconds = seconds_ff;
endmodule : scr_interval_rom
`default_nettype wire

// *** hw/scr_pkg.sv ***
// types for the sensor configuration and result register bank
`default_nettype none
package scr_pkg;
    typedef enum logic [1:0] {
        SCR_IDLE = 2'b00,
        SCR_WAIT = 2'b01,
        SCR_CAL = 2'b10
    } scr_cal_state_t;

    typedef struct packed {
        logic [15:0] config_ff;
        logic [15:0] osc_ff;
        logic [15:0] bg_ff;
        logic [15:0] avg_ff;
        logic [15:0] obj_ff;
        logic [15:0] conv_ff;
        logic test_mode_ff;
        logic wp_off_ff;
        logic [15:0] rdata_ff;
        logic rvalid_ff;
        logic fe_ff;
        scr_cal_state_t cal_ff;
        logic [7:0] sec_left_ff;
        logic [26:0] tick_cnt_ff;
        logic cal_start_ff;
        logic [1:0] pin1_ff;
        logic [1:0] pin2_ff;
        logic ntc_ff;
        logic curv_neg_ff;
        logic ofs_en_ff;
        logic [10:0] ir_ofs_n_ff;
        logic [10:0] t_ofs_n_ff;
        logic [10:0] ir_depth_ff;
        logic [10:0] t_depth_ff;
        logic nv_wr_ff;
        logic [6:0] nv_addr_ff;
        logic [15:0] nv_data_ff;
    } scr_state_t;
endpackage : scr_pkg
`default_nettype wire

// *** hw/scr_regs.sv ***
// sensor configuration and result register bank, host register port
`include "scr_consts.svh"
// Contract
// - first pin function from two-bit selector: IR, Tobj, relay threshold, PWM_n
// - second pin function from two-bit selector: temp, Tamb, comparator, PWM
// - type bit 0 means positive coefficient, 1 negative coefficient
// - curvature sign from positive-coeff bit if type 0, else negative bit
// - four-bit code picks offset calibration interval, zero to 220 s
// - trim and averaging settings never read back from internal registers
// - trim and averaging writes only in test mode; memory also needs unlock
// - offset measurement bit 0 enables both channels, 1 suppresses
// - IR offset average 512 when bit 0, 1024 when bit 1
// - temperature offset average 512 when bit 0, 1024 when bit 1
// - IR moving average depth 64 to 1024 from three-bit field
// - temperature moving average depth uses same mapping
// - conversion result always readable, written only in test mode
// - object temperature result readable, written only in test mode
// - result word: data 15:4, overflow 3, underflow 2, fatal 1
// - overflow sets flag and forces data to all ones
// - underflow sets flag and forces data to zero, unless overflow is also set
// - fatal memory error in bit 1, bit 0 always zero
// - uncorrectable memory error sets the fatal indication
// - test mode only when upper seven mode bits equal 1011001b
// - write unlock only when key equals 1100101b, else protected
`default_nettype none
module scr_regs (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic nv_rd_valid,
    input wire logic [6:0] nv_rd_addr,
    input wire logic [15:0] nv_rd_data,
    input wire logic nv_multi_err,
    input wire logic conv_valid,
    input wire logic [15:0] conv_data,
    input wire logic obj_valid,
    input wire logic [11:0] obj_data,
    input wire logic obj_over,
    input wire logic obj_under,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    output logic nv_wr,
    output logic [6:0] nv_addr,
    output logic [15:0] nv_wdata,
    output logic [1:0] first_pin_function_select,
    output logic [1:0] second_pin_function_select,
    output logic thermistor_type_bit,
    output logic curvature_negative,
    output logic offset_measure_enable,
    output logic [10:0] ir_offset_count,
    output logic [10:0] temp_offset_count,
    output logic [10:0] ir_average_points,
    output logic [10:0] temp_average_points,
    output logic calibration_start,
    output logic test_mode,
    output logic write_unlocked,
    output logic [15:0] oscillator_trim,
    output logic [15:0] bandgap_trim
);
    scr_pkg::scr_state_t s_ff;
    scr_pkg::scr_state_t nxt_s;
    logic [7:0] interval_s;
    logic [15:0] cfg_w;
    logic [15:0] avg_w;

    scr_interval_rom u_rom (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .code(s_ff.config_ff[`SCR_CFG_INTERVAL_LSB +: 4]),
        .seconds(interval_s)
    );

    // ==========================================================
    // depth decode: 00b..100b gives 64 << code, larger codes clamp
    function automatic logic [10:0] scr_depth(input logic [2:0] code);
        logic [10:0] d;
        d = 11'h040;
        if (code <= 3'h4) begin
            d = 11'h040 << code;
        end else begin
            d = 11'h400;
        end
        return d;
    endfunction : scr_depth

    // ==========================================================
    // next state
    always_comb begin
        nxt_s = s_ff;
        nxt_s.rvalid_ff = 1'b0;
        nxt_s.nv_wr_ff = 1'b0;
        nxt_s.cal_start_ff = 1'b0;
        cfg_w = s_ff.config_ff;
        avg_w = s_ff.avg_ff;

        // register writes
        if (reg_wr) begin
            if (reg_addr == `SCR_ADDR_CONFIG) begin
                nxt_s.config_ff = reg_wdata;
            end else if (reg_addr == `SCR_ADDR_MODE) begin
                nxt_s.test_mode_ff =
                    (reg_wdata[15:9] == `SCR_TEST_KEY);
            end else if (reg_addr == `SCR_ADDR_WP_KEY) begin
                nxt_s.wp_off_ff =
                    (reg_wdata[6:0] == `SCR_WP_KEY);
            end else if (s_ff.test_mode_ff) begin
                if (reg_addr == `SCR_ADDR_OSC_TRIM) begin
                    nxt_s.osc_ff = reg_wdata;
                end else if (reg_addr == `SCR_ADDR_BANDGAP_TRIM) begin
                    nxt_s.bg_ff = reg_wdata;
                end else if (reg_addr == `SCR_ADDR_AVG_SETTINGS) begin
                    nxt_s.avg_ff = reg_wdata;
                end else if (reg_addr == `SCR_ADDR_OBJ_RESULT) begin
                    nxt_s.obj_ff = reg_wdata & 16'hFFFE;
                end else if (reg_addr == `SCR_ADDR_CONV_RESULT) begin
                    nxt_s.conv_ff = reg_wdata;
                end
            end
            // non-volatile copy of the gated settings
            if (s_ff.test_mode_ff && s_ff.wp_off_ff
                    && reg_addr >= `SCR_ADDR_OSC_TRIM
                    && reg_addr <= `SCR_ADDR_AVG_SETTINGS) begin
                nxt_s.nv_wr_ff = 1'b1;
                nxt_s.nv_addr_ff = reg_addr;
                nxt_s.nv_data_ff = reg_wdata;
            end
        end

        // boot load from memory fills the gated settings
        if (nv_rd_valid) begin
            if (nv_rd_addr == `SCR_ADDR_OSC_TRIM) begin
                nxt_s.osc_ff = nv_rd_data;
            end else if (nv_rd_addr == `SCR_ADDR_BANDGAP_TRIM) begin
                nxt_s.bg_ff = nv_rd_data;
            end else if (nv_rd_addr == `SCR_ADDR_AVG_SETTINGS) begin
                nxt_s.avg_ff = nv_rd_data;
            end
        end

        // fatal flag: sticky, set wins; cleared by leaving test mode while unlocked
        if (s_ff.test_mode_ff && s_ff.wp_off_ff
                && !nxt_s.test_mode_ff) begin
            nxt_s.fe_ff = 1'b0;
        end
        if (nv_multi_err) begin
            nxt_s.fe_ff = 1'b1;
        end

        // live results from the conversion and linearisation paths
        if (conv_valid) begin
            nxt_s.conv_ff = conv_data;
        end
        if (obj_valid) begin
            if (obj_over) begin
                nxt_s.obj_ff[15:4] = `SCR_DATA_MAX;
            end else if (obj_under) begin
                nxt_s.obj_ff[15:4] = `SCR_DATA_MIN;
            end else begin
                nxt_s.obj_ff[15:4] = obj_data;
            end
            nxt_s.obj_ff[`SCR_RES_OVF] = obj_over;
            nxt_s.obj_ff[`SCR_RES_UNF] = obj_under & ~obj_over;
        end
        nxt_s.obj_ff[`SCR_RES_FE] = nxt_s.fe_ff;
        nxt_s.obj_ff[0] = 1'b0;

        // reads: gated settings return zero, though the bank still holds them
        if (reg_rd) begin
            nxt_s.rvalid_ff = 1'b1;
            if (reg_addr == `SCR_ADDR_CONFIG) begin
                nxt_s.rdata_ff = s_ff.config_ff;
            end else if (reg_addr == `SCR_ADDR_OBJ_RESULT) begin
                nxt_s.rdata_ff = s_ff.obj_ff;
            end else if (reg_addr == `SCR_ADDR_CONV_RESULT) begin
                nxt_s.rdata_ff = s_ff.conv_ff;
            end else begin
                nxt_s.rdata_ff = `SCR_RST_WORD;
            end
        end

        // decoded steering outputs
        cfg_w = nxt_s.config_ff;
        avg_w = nxt_s.avg_ff;
        nxt_s.pin1_ff = cfg_w[`SCR_CFG_FIRST_LSB +: 2];
        nxt_s.pin2_ff = cfg_w[`SCR_CFG_SECOND_LSB +: 2];
        nxt_s.ntc_ff = cfg_w[`SCR_CFG_NTC];
        nxt_s.curv_neg_ff = cfg_w[`SCR_CFG_NTC] ? cfg_w[`SCR_CFG_CURV_NEG]
            : cfg_w[`SCR_CFG_CURV_POS];
        nxt_s.ofs_en_ff = ~avg_w[`SCR_AVG_OFS_DIS];
        nxt_s.ir_ofs_n_ff = avg_w[`SCR_AVG_IR_OFS] ? 11'h400
            : 11'h200;
        nxt_s.t_ofs_n_ff = avg_w[`SCR_AVG_T_OFS] ? 11'h400
            : 11'h200;
        nxt_s.ir_depth_ff = scr_depth(avg_w[`SCR_AVG_IR_LSB +: 3]);
        nxt_s.t_depth_ff = scr_depth(avg_w[`SCR_AVG_T_LSB +: 3]);

        // calibration interval timer, one second ticks
        case (s_ff.cal_ff)
            scr_pkg::SCR_IDLE: begin
                nxt_s.tick_cnt_ff = 27'h0;
                if (interval_s != 8'h00 && s_ff.ofs_en_ff) begin
                    nxt_s.sec_left_ff = interval_s;
                    nxt_s.cal_ff = scr_pkg::SCR_WAIT;
                end
            end
            scr_pkg::SCR_WAIT: begin
                if (interval_s == 8'h00 || !s_ff.ofs_en_ff) begin
                    nxt_s.cal_ff = scr_pkg::SCR_IDLE;
                end else if (s_ff.tick_cnt_ff
                        == 27'(`SCR_SEC_CYCLES - 1)) begin
                    nxt_s.tick_cnt_ff = 27'h0;
                    nxt_s.sec_left_ff = s_ff.sec_left_ff - 8'h01;
                    if (s_ff.sec_left_ff == 8'h01) begin
                        nxt_s.cal_ff = scr_pkg::SCR_CAL;
                    end
                end else begin
                    nxt_s.tick_cnt_ff = s_ff.tick_cnt_ff + 27'h1;
                end
            end
            scr_pkg::SCR_CAL: begin
                nxt_s.cal_start_ff = 1'b1;
                nxt_s.cal_ff = scr_pkg::SCR_IDLE;
            end
            default: begin
                nxt_s.cal_ff = scr_pkg::SCR_IDLE;
            end
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign reg_rdata = s_ff.rdata_ff;
    assign reg_rvalid = s_ff.rvalid_ff;
    assign nv_wr = s_ff.nv_wr_ff;
    assign nv_addr = s_ff.nv_addr_ff;
    assign nv_wdata = s_ff.nv_data_ff;
    assign first_pin_function_select = s_ff.pin1_ff;
    assign second_pin_function_select = s_ff.pin2_ff;
    assign thermistor_type_bit = s_ff.ntc_ff;
    assign curvature_negative = s_ff.curv_neg_ff;
    assign offset_measure_enable = s_ff.ofs_en_ff;
    assign ir_offset_count = s_ff.ir_ofs_n_ff;
    assign temp_offset_count = s_ff.t_ofs_n_ff;
    assign ir_average_points = s_ff.ir_depth_ff;
    assign temp_average_points = s_ff.t_depth_ff;
    assign calibration_start = s_ff.cal_start_ff;
    assign test_mode = s_ff.test_mode_ff;
    assign write_unlocked = s_ff.wp_off_ff;
    assign oscillator_trim = s_ff.osc_ff;
    assign bandgap_trim = s_ff.bg_ff;
endmodule : scr_regs
`default_nettype wire

// *** verif/scr_host_model.sv ***
// host controller model on the register port
`include "scr_consts.svh"
`default_nettype none
module scr_host_model (
    input wire logic ref_clk,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    output logic reg_wr,
    output logic reg_rd,
    output logic [6:0] reg_addr,
    output logic [15:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 16'h0000;
    end
    // prompt or slow host: random idle gap
    task automatic idle();
        repeat ($urandom % 3) @(posedge ref_clk);
    endtask : idle
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        idle();
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= (a == `SCR_ADDR_AVG_SETTINGS) ? d & 16'hFFFB : d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        // released lines do not keep their last value
        reg_wdata <= ~reg_wdata;
        reg_addr <= ~reg_addr;
        // let the write land so callers see the new state
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        idle();
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge ref_clk);
        d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
    endtask : rd
endmodule : scr_host_model
`default_nettype wire

// *** verif/scr_regs_asserts.sv ***
// port assertions for the register bank
`include "scr_consts.svh"
`default_nettype none
module scr_regs_asserts (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic nv_rd_valid,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic nv_wr,
    input wire logic test_mode,
    input wire logic write_unlocked,
    input wire logic [10:0] ir_offset_count,
    input wire logic [10:0] temp_offset_count,
    input wire logic [10:0] ir_average_points,
    input wire logic [10:0] temp_average_points,
    input wire logic [15:0] oscillator_trim
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    // ==========================================================
    // host port steps
    sequence s_mode_wr;
        reg_wr && reg_addr == `SCR_ADDR_MODE;
    endsequence
    sequence s_key_wr;
        reg_wr && reg_addr == `SCR_ADDR_WP_KEY;
    endsequence
    chk_rvalid_after_rd: assert property (
        $past(nrst) |-> reg_rvalid == $past(reg_rd))
        else $error("read valid not one cycle after read");
    chk_hidden_read_zero: assert property (
        reg_rd && (reg_addr inside {7'h05, 7'h06, 7'h07})
        |=> reg_rdata == 16'h0000)
        else $error("trim or averaging read not zero");
    chk_test_mode_key: assert property (
        s_mode_wr |=> test_mode == ($past(reg_wdata[15:9]) == `SCR_TEST_KEY))
        else $error("test mode does not follow key");
    chk_unlock_key: assert property (
        s_key_wr |=> write_unlocked == ($past(reg_wdata[6:0]) == `SCR_WP_KEY))
        else $error("unlock does not follow key");
    chk_nv_needs_unlock: assert property (
        nv_wr |-> $past(reg_wr && write_unlocked && test_mode))
        else $error("memory write while protected");
    chk_trim_gated: assert property (
        reg_wr && reg_addr == `SCR_ADDR_OSC_TRIM && !test_mode && !nv_rd_valid
        |=> $stable(oscillator_trim))
        else $error("trim written outside test mode");
    chk_offset_counts: assert property (
        $past(nrst) |-> ir_offset_count inside {11'h200, 11'h400}
        && temp_offset_count inside {11'h200, 11'h400})
        else $error("offset count not 512 or 1024");
    chk_average_points: assert property (
        $past(nrst) |-> $onehot(ir_average_points) && ir_average_points >= 64
        && $onehot(temp_average_points) && temp_average_points >= 64)
        else $error("average depth out of range");
endmodule : scr_regs_asserts
bind scr_regs scr_regs_asserts u_chk (.*);
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking testbench for the register bank
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, nrst, reg_wr, reg_rd, nv_rd_valid, nv_multi_err;
    logic conv_valid, obj_valid, obj_over, obj_under, nv_wr, reg_rvalid;
    logic thermistor_type_bit, curvature_negative, offset_measure_enable;
    logic calibration_start, test_mode, write_unlocked;
    logic [6:0] reg_addr, nv_rd_addr, nv_addr, nv_last;
    logic [15:0] reg_wdata, nv_rd_data, conv_data, reg_rdata, nv_wdata, rd, w;
    logic [15:0] oscillator_trim, bandgap_trim, nv_dat;
    logic [11:0] obj_data;
    logic [1:0] first_pin_function_select, second_pin_function_select;
    logic [10:0] ir_offset_count, temp_offset_count, ir_average_points;
    logic [10:0] temp_average_points;
    logic [6:0] hid [6] = '{7'h05, 7'h06, 7'h07, 7'h0B, 7'h0C, 7'h7F};
    int error_cnt = 0, num_checks = 0, nv_cnt = 0, fe = 0, cal_cnt = 0;
    scr_regs uut (.*);
    scr_host_model u_host (.*);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (nv_wr === 1'b1) begin
            nv_cnt <= nv_cnt + 1;
            nv_last <= nv_addr;
            nv_dat <= nv_wdata;
        end
        if (calibration_start === 1'b1) begin
            cal_cnt <= cal_cnt + 1;
        end
    end
    // ==========================================================
    // compare and drive helpers
    task automatic bad(input logic [15:0] got, input int exp);
        num_checks++;
        if (got !== 16'(exp)) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, 16'(exp));
        end
    endtask : bad
    task automatic cmp_rd(input logic [6:0] a, input int exp);
        u_host.rd(a, rd);
        bad(rd, exp);
    endtask : cmp_rd
    task automatic cmp_port(input logic [15:0] got, input int exp);
        @(posedge ref_clk);
        bad(got, exp);
    endtask : cmp_port
    task automatic do_reset();
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask : do_reset
    task automatic obj_chk(input int d, input int ov, input int un);
        @(posedge ref_clk);
        obj_valid <= 1'b1;
        obj_data <= 12'(d);
        obj_over <= ov[0];
        obj_under <= un[0];
        @(posedge ref_clk);
        obj_valid <= 1'b0;
        d = ov ? 'hFFF : (un ? 0 : d);
        cmp_rd(7'h09, d << 4 | ov << 3 | un << 2 | fe << 1);
    endtask : obj_chk
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #300us;
        error_cnt++;
        wrap_up();
    end
    // ==========================================================
    // tests
    initial begin
        nrst = 1'b0;
        {nv_rd_valid, nv_multi_err, conv_valid, obj_valid} = 4'h0;
        {obj_over, obj_under, nv_rd_addr, nv_rd_data} = '0;
        {conv_data, obj_data} = '0;
        void'($urandom(24));
        do_reset();
        cmp_port(16'(offset_measure_enable), 1);
        cmp_port(16'(ir_offset_count), 512);
        cmp_port(16'(temp_average_points), 64);
        foreach (hid[k]) cmp_rd(hid[k], 0);
        $display("test reset_and_hidden done");
        u_host.wr(7'h0B, 16'hB000);
        cmp_port(16'(test_mode), 0);
        for (int t = 0; t < 2; t++) begin
            u_host.wr(7'h0A, 16'h1234);
            u_host.wr(7'h09, 16'h5670);
            u_host.wr(7'h05, 16'hABCD);
            cmp_rd(7'h0A, t ? 'h1234 : 0);
            cmp_rd(7'h09, t ? 'h5670 : 0);
            cmp_port(oscillator_trim, t ? 'hABCD : 0);
            u_host.wr(7'h0B, 16'hB200);
            cmp_port(16'(test_mode), 1);
        end
        cmp_rd(7'h05, 0);
        cmp_port(16'(nv_cnt), 0);
        @(posedge ref_clk);
        nv_rd_valid <= 1'b1;
        nv_rd_addr <= 7'h06;
        nv_rd_data <= 16'h1357;
        @(posedge ref_clk);
        nv_rd_valid <= 1'b0;
        @(posedge ref_clk);
        cmp_port(bandgap_trim, 'h1357);
        $display("test mode_gating done");
        for (int i = 0; i < 4; i++) begin
            w = ($urandom & 16'h07F0) | 16'((3 - i) << 2 | i);
            u_host.wr(7'h08, w);
            cmp_rd(7'h08, w);
            bad(16'(first_pin_function_select), w[1:0]);
            bad(16'(second_pin_function_select), w[3:2]);
            bad(16'(thermistor_type_bit), w[6]);
            bad(16'(curvature_negative), w[6] ? w[5] : w[4]);
        end
        $display("test config done");
        for (int i = 0; i < 6; i++) begin
            w = ($urandom & 16'h001B) | 16'(i << 5 | (5 - i) << 8);
            u_host.wr(7'h07, w);
            cmp_rd(7'h07, 0);
            bad(16'(offset_measure_enable), !w[1]);
            bad(16'(ir_offset_count), w[3] ? 1024 : 512);
            bad(16'(temp_offset_count), w[4] ? 1024 : 512);
            bad(16'(ir_average_points), 64 << (i > 4 ? 4 : i));
            bad(16'(temp_average_points), 64 << (i < 1 ? 4 : 5 - i));
        end
        $display("test averaging done");
        u_host.wr(7'h0C, 16'h0064);
        cmp_port(16'(write_unlocked), 0);
        u_host.wr(7'h0C, 16'h0065);
        cmp_port(16'(write_unlocked), 1);
        u_host.wr(7'h07, 16'h0120);
        @(posedge ref_clk);
        cmp_port(16'(nv_cnt), 1);
        bad(16'(nv_last), 7);
        bad(nv_dat, 'h0120);
        $display("test unlock done");
        w = 16'($urandom);
        @(posedge ref_clk);
        conv_valid <= 1'b1;
        conv_data <= w;
        @(posedge ref_clk);
        conv_valid <= 1'b0;
        cmp_rd(7'h0A, w);
        obj_chk($urandom & 'hFFF, 0, 0);
        obj_chk('h123, 1, 0);
        obj_chk('h456, 0, 1);
        @(posedge ref_clk);
        nv_multi_err <= 1'b1;
        @(posedge ref_clk);
        nv_multi_err <= 1'b0;
        fe = 1;
        obj_chk('h789, 0, 0);
        // leaving test mode while unlocked clears the fatal flag
        u_host.wr(7'h0B, 16'h0000);
        cmp_port(16'(test_mode), 0);
        fe = 0;
        obj_chk('hABC, 0, 0);
        u_host.wr(7'h0B, 16'hB200);
        $display("test results done");
        do_reset();
        cmp_port(16'(test_mode), 0);
        bad(16'(write_unlocked), 0);
        cmp_rd(7'h08, 0);
        // shortest nonzero interval is far longer than the whole run
        bad(16'(cal_cnt), 0);
        $display("test second_reset done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
